// >>> core/ioc_pkg.sv
// Purpose: shared constants and field layouts for the i/o port control latches
// Assumes: 8-bit processor i/o space, 20 MHz mclk
// Notes:   port groups are four addresses wide, matched on address bits 7..2
`default_nettype none

package ioc_pkg;

  // port group bases (low two address bits ignored)
  localparam logic [7:0] PORT_CFG      = 8'hFC;  // tape sound out / config readback
  localparam logic [7:0] PORT_PRINTER  = 8'hF8;  // printer data / printer status
  localparam logic [7:0] PORT_DRIVE    = 8'hF4;  // floppy drive config
  localparam logic [7:0] PORT_DISK     = 8'hF0;  // disk controller registers
  localparam logic [7:0] PORT_SYSCFG   = 8'hEC;  // system config / tick clear
  localparam logic [7:0] PORT_SERIAL   = 8'hE8;  // uart registers
  localparam logic [7:0] PORT_NMI      = 8'hE4;  // nmi enable / nmi sources
  localparam logic [7:0] PORT_IRQ      = 8'hE0;  // irq enable / irq pending
  localparam logic [7:0] PORT_BOOT     = 8'h9C;  // boot rom control
  localparam logic [7:0] PORT_SOUND    = 8'h90;  // sound output latch
  localparam logic [7:0] PORT_OPCTL    = 8'h84;  // operation control

  // serial register selects inside its group
  localparam logic [1:0] SER_MASTER_RST = 2'h0;  // write: uart master reset
  localparam logic [1:0] SER_RX_HOLD    = 2'h3;  // read: receive holding

  // value returned for reserved or unmapped reads
  localparam logic [7:0] IDLE_READ     = 8'hFF;
  // reset value of every write-only latch
  localparam logic [7:0] LATCH_RESET   = 8'h00;

  // drive config write stall: least 1 us, rounded up to whole cycles
  localparam int DRIVE_WAIT_NS  = 1000;
  localparam int MCLK_PERIOD_NS = 50;
  localparam int DRIVE_WAIT_CYC = (DRIVE_WAIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [4:0] DRIVE_WAIT_CNT = 5'(DRIVE_WAIT_CYC);

  // width of the main pin synchroniser, slot 10 spare
  localparam int PIN_W = 11;

  // operation control layout, bit 7 first
  typedef struct packed {
    logic video_page;         // cpu video page select
    logic remap_dest_page;    // 1 lower 32K of lower bank
    logic remap_enable;       // page remapping on
    logic remap_source_page;  // 1 upper 32K of upper bank
    logic inverse_video;      // inverse video on
    logic wide_column;        // 1 = 80 columns, 0 = 64
    logic map_mode_bit_high;  // memory-map mode, high bit
    logic map_mode_bit_low;   // memory-map mode, low bit
  } ioc_opctl_t;

  // system config latch layout
  typedef struct packed {
    logic speed_fast;             // 1 = 4 MHz
    logic rsvd5;                  // reads zero
    logic external_bus_enable;    // external bus on
    logic alt_charset_enable;     // alternate set on
    logic narrow_column_select;   // 32/40 columns
    logic motor_on_sound_disable; // motor on, sound off
    logic rsvd0;                  // reads zero
  } ioc_syscfg_t;

  // floppy drive config layout
  typedef struct packed {
    logic       double_density_select;  // 1 = mfm
    logic       disk_wait_gen_enable;   // controller sync waits
    logic       write_precomp_enable;   // precompensation on
    logic       head_side_select;       // 1 = side 1
    logic [1:0] rsvd;                   // reserved
    logic [1:0] drive_select;           // drive selects
  } ioc_drive_t;

  // irq enable / pending layout
  typedef struct packed {
    logic rsvd7;                  // reserved
    logic uart_error_irq_enable;  // uart error
    logic rx_full_irq_enable;     // receive full
    logic tx_empty_irq_enable;    // transmit empty
    logic ext_bus_irq_enable;     // external bus
    logic clock_tick_irq_enable;  // clock tick
    logic [1:0] rsvd;             // reserved
  } ioc_irqen_t;

  // external register file access (disk controller or uart)
  typedef struct packed {
    logic       wr_stb;  // one-cycle write strobe
    logic       rd_stb;  // one-cycle read strobe
    logic [1:0] sel;     // register select
    logic [7:0] wdata;   // write data
  } ioc_ext_acc_t;

endpackage : ioc_pkg

`default_nettype wire

// >>> core/ioc_io_port_control.sv
// Purpose: i/o port decoder and system control latches for an 8-bit cpu
// Assumes: io_wr / io_rd are one-cycle pulses on mclk; pins are asynchronous
// Notes:   read data is registered and valid one cycle after io_rd
`default_nettype none

// Behaviour
// R1 - write FC group latches tape sound bit 0
// R2 - read FC group returns config latch state
// R3 - write F8 group sends byte to printer
// R4 - read F8 group returns printer status bits
// R5 - F0..F3 routed to external disk controller
// R6 - F4 write latches drive selects, side, precomp
// R7 - drive bit 6 waits, bit 7 density
// R8 - every drive config write stalls cpu briefly
// R9 - EC write latches system configuration bits
// R10 - EC read clears pending clock tick
// R11 - serial writes: reset, baud, control, transmit
// R12 - serial reads: modem, status, receive clears ready
// R13 - E4 write latches two nmi enables
// R14 - E4 read returns active-low nmi sources
// R15 - E0 write latches five irq enables
// R16 - E0 read reports pending maskable interrupts
// R17 - 9C write bit 0 enables boot rom
// R18 - 90 write latches sound data bit 0
// R19 - 84 write bits 1:0 set map mode
// R20 - operation bit 2 width, bit 3 inverse
// R21 - operation bits 4..6 control page remapping
// R22 - operation bit 7 selects video page
// R23 - boot rom only active in mode 0
// R24 - reset clears all write-only latches
module ioc_io_port_control (
  input  wire logic                  mclk, // 20 MHz clock
  input  wire logic                  nrst, // async reset, active low
  input  wire logic [7:0]            io_addr, // i/o port address
  input  wire logic                  io_wr, // one-cycle write pulse
  input  wire logic                  io_rd, // one-cycle read pulse
  input  wire logic [7:0]            io_wdata, // write data
  output var  logic [7:0]            io_rdata_q, // registered read data
  output var  logic                  io_wait_q, // cpu wait request
  input  wire logic [7:0]            disk_rdata, // disk controller read data
  input  wire logic [7:0]            serial_rdata, // uart read data
  input  wire logic [3:0]            printer_stat_pin, // fault, select, paper, busy
  input  wire logic                  disk_ctrl_request, // done request pin
  input  wire logic                  disk_data_request, // data request pin
  input  wire logic                  motor_timeout, // motor timeout pin
  input  wire logic                  clock_tick, // clock tick pin
  input  wire logic                  ext_bus_irq, // external bus request pin
  input  wire logic                  tx_empty, // uart transmit empty pin
  input  wire logic                  rx_full, // uart receive full pin
  input  wire logic                  uart_error, // uart error pin
  output var  ioc_pkg::ioc_ext_acc_t disk_acc_q, // disk controller access
  output var  ioc_pkg::ioc_ext_acc_t serial_acc_q, // uart access
  output var  logic                  uart_master_reset_q, // uart reset pulse
  output var  logic                  rx_data_ready_flag_clr_q, // receive read pulse
  output var  logic [7:0]            printer_data_out_q, // printer character
  output var  logic                  printer_strobe_q, // printer write pulse
  output var  logic                  tape_sound_out_q, // tape port sound level
  output var  logic                  sound_data_q, // sound port level
  output var  ioc_pkg::ioc_syscfg_t  system_config_q, // system config latch
  output var  ioc_pkg::ioc_drive_t   floppy_drive_config_q, // drive config latch
  output var  ioc_pkg::ioc_opctl_t   operation_control_q, // operation register
  output var  ioc_pkg::ioc_irqen_t   irq_enable_q, // irq enables
  output var  logic [1:0]            nmi_enable_q, // {done, motor} nmi enables
  output var  logic                  boot_rom_active_q, // boot rom mapped in
  output var  logic                  irq_q, // maskable interrupt out
  output var  logic                  nmi_q // nmi request out
);
  import ioc_pkg::*;

  // group match on address bits 7..2
  function automatic logic in_group(input logic [7:0] addr, input logic [7:0] base);
    in_group = (addr[7:2] == base[7:2]);
  endfunction : in_group

  // reset release chain
  logic rst_meta_q;   // first stage
  logic rst_n_q;      // released reset used below

  // pin synchronisers: three stages plus agreed value
  logic [PIN_W-1:0] pin_raw;     // gathered pins
  logic [PIN_W-1:0] pin_s1_q;    // stage one
  logic [PIN_W-1:0] pin_s2_q;    // stage two
  logic [PIN_W-1:0] pin_s3_q;    // stage three
  logic [PIN_W-1:0] pin_q;       // accepted level
  logic [PIN_W-1:0] pin_d;       // next accepted level

  // latch storage
  logic       boot_enable_q;     // boot rom request bit
  logic       tick_pending_q;    // sticky clock tick
  logic       tick_pending_d;    // next sticky tick
  logic [4:0] wait_cnt_q;        // drive write stall counter
  logic [4:0] wait_cnt_d;        // next stall count
  logic       disk_sync_wait_q;  // waiting for controller
  logic       disk_sync_wait_d;  // next controller wait

  // decoded strobes
  wire wr_cfg    = io_wr & in_group(io_addr, PORT_CFG);
  wire wr_prn    = io_wr & in_group(io_addr, PORT_PRINTER);
  wire wr_drive  = io_wr & in_group(io_addr, PORT_DRIVE);
  wire wr_syscfg = io_wr & in_group(io_addr, PORT_SYSCFG);
  wire wr_nmi    = io_wr & in_group(io_addr, PORT_NMI);
  wire wr_irq    = io_wr & in_group(io_addr, PORT_IRQ);
  wire wr_boot   = io_wr & in_group(io_addr, PORT_BOOT);
  wire wr_sound  = io_wr & in_group(io_addr, PORT_SOUND);
  wire wr_opctl  = io_wr & in_group(io_addr, PORT_OPCTL);
  wire hit_disk  = in_group(io_addr, PORT_DISK);
  wire hit_ser   = in_group(io_addr, PORT_SERIAL);
  wire rd_syscfg = io_rd & in_group(io_addr, PORT_SYSCFG);

  // synchronised pin levels
  wire [3:0] prn_stat   = pin_q[3:0];
  wire       sy_done    = pin_q[4];
  wire       sy_drq     = pin_q[5];
  wire       sy_motor   = pin_q[6];
  wire       sy_tick    = pin_q[7];
  wire       sy_ext     = pin_q[8];
  wire       sy_tx      = pin_q[9];
  // slot 10 spare, tied low
  // rx_full, uart_error on own chain
  logic [1:0] ser_s1_q;  // rx/err stage one
  logic [1:0] ser_s2_q;  // rx/err stage two
  logic [1:0] ser_s3_q;  // rx/err stage three
  logic [1:0] ser_q;     // rx/err accepted
  wire  [1:0] ser_d = (ser_s2_q == ser_s3_q) ? ser_s3_q : ser_q;

  // gathered pins for the main synchroniser
  assign pin_raw = {1'b0, tx_empty, ext_bus_irq, clock_tick, motor_timeout,
                    disk_data_request, disk_ctrl_request, printer_stat_pin};

  // accept a change once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_agree
      assign pin_d[gi] = (pin_s2_q[gi] == pin_s3_q[gi]) ? pin_s3_q[gi] : pin_q[gi];
    end
  endgenerate

  // tick edge from the accepted level
  logic tick_prev_q;  // previous accepted tick
  wire  tick_rise = sy_tick & ~tick_prev_q;

  // R10 tick clear on read; a new tick wins over the clear
  assign tick_pending_d = tick_rise ? 1'b1 : (rd_syscfg ? 1'b0 : tick_pending_q);

  // R16 pending interrupt sources
  wire [7:0] irq_pending = {1'b0, ser_q[1], ser_q[0], sy_tx, sy_ext, tick_pending_q, 2'b00};

  // R8 drive config write reloads the stall counter
  assign wait_cnt_d = wr_drive ? DRIVE_WAIT_CNT :
                      (wait_cnt_q != 5'h0) ? wait_cnt_q - 5'h1 : 5'h0;

  // R7 controller sync wait on data access while enabled
  assign disk_sync_wait_d = (hit_disk & (io_wr | io_rd) & (io_addr[1:0] == 2'h3)
                             & floppy_drive_config_q.disk_wait_gen_enable)
                            ? ~(sy_drq | sy_done)
                            : (disk_sync_wait_q & ~(sy_drq | sy_done));

  // R14 active-low nmi sources, reset negated while running
  wire [7:0] nmi_status = {~sy_done, ~sy_motor, rst_n_q, 4'h0, 1'b0};

  // R2 config readback
  wire [7:0] cfg_read = {1'b0, system_config_q.speed_fast, 1'b0,
                         system_config_q.external_bus_enable,
                         system_config_q.alt_charset_enable,
                         system_config_q.narrow_column_select,
                         system_config_q.motor_on_sound_disable, 1'b0};

  // R4 printer status, low nibble reserved
  wire [7:0] prn_read = {prn_stat, 4'h0};

  // read data selection; reserved groups give the idle value
  wire [7:0] rdata_d =
    ~io_rd ? io_rdata_q :
    in_group(io_addr, PORT_CFG) ? cfg_read :
    in_group(io_addr, PORT_PRINTER) ? prn_read :
    hit_disk ? disk_rdata :
    (hit_ser & (io_addr[1:0] != 2'h1)) ? serial_rdata :
    in_group(io_addr, PORT_NMI) ? nmi_status :
    in_group(io_addr, PORT_IRQ) ? irq_pending :
    IDLE_READ;

  // R23 boot rom gated by map mode 0
  wire boot_active_d = boot_enable_q & ~operation_control_q.map_mode_bit_high
                       & ~operation_control_q.map_mode_bit_low;

  // interrupt and nmi outputs
  wire irq_d = |(irq_pending & irq_enable_q);
  wire nmi_d = (sy_done & nmi_enable_q[1]) | (sy_motor & nmi_enable_q[0]);

  // reset release: async assert, two-flop release
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // pin synchronisers
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_q    <= '0;
      ser_s1_q <= '0;
      ser_s2_q <= '0;
      ser_s3_q <= '0;
      ser_q    <= '0;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q    <= pin_d;
      ser_s1_q <= {uart_error, rx_full};
      ser_s2_q <= ser_s1_q;
      ser_s3_q <= ser_s2_q;
      ser_q    <= ser_d;
    end
  end

  // R24 all write-only latches clear on reset
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      tape_sound_out_q      <= 1'b0;
      sound_data_q          <= 1'b0;
      system_config_q       <= ioc_syscfg_t'(7'h00);
      floppy_drive_config_q <= ioc_drive_t'(LATCH_RESET);
      operation_control_q   <= ioc_opctl_t'(LATCH_RESET);
      irq_enable_q          <= ioc_irqen_t'(LATCH_RESET);
      nmi_enable_q          <= 2'h0;
      boot_enable_q         <= 1'b0;
      printer_data_out_q    <= LATCH_RESET;
    end
    else
    begin
      // R1 tape sound level
      if (wr_cfg)
        tape_sound_out_q <= io_wdata[0];
      // R18 sound port level
      if (wr_sound)
        sound_data_q <= io_wdata[0];
      // R9 system configuration bits, reserved kept zero
      if (wr_syscfg)
        system_config_q <= ioc_syscfg_t'({io_wdata[6], 1'b0, io_wdata[4:1], 1'b0});
      // R6 drive selects, side, precomp; R7 wait and density
      if (wr_drive)
        floppy_drive_config_q <= ioc_drive_t'({io_wdata[7:4], 2'b00, io_wdata[1:0]});
      // R19 map mode; R20 R21 R22 display and paging
      if (wr_opctl)
        operation_control_q <= ioc_opctl_t'(io_wdata);
      // R15 irq enables in bits 6..2
      if (wr_irq)
        irq_enable_q <= ioc_irqen_t'({1'b0, io_wdata[6:2], 2'b00});
      // R13 nmi enables, bit 7 done, bit 6 motor
      if (wr_nmi)
        nmi_enable_q <= io_wdata[7:6];
      // R17 boot rom request
      if (wr_boot)
        boot_enable_q <= io_wdata[0];
      // R3 printer character
      if (wr_prn)
        printer_data_out_q <= io_wdata;
    end
  end

  // external register strobes and one-cycle pulses
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      disk_acc_q               <= '0;
      serial_acc_q             <= '0;
      uart_master_reset_q      <= 1'b0;
      rx_data_ready_flag_clr_q <= 1'b0;
      printer_strobe_q         <= 1'b0;
    end
    else
    begin
      // R5 disk controller pass-through
      disk_acc_q   <= '{wr_stb: io_wr & hit_disk, rd_stb: io_rd & hit_disk,
                        sel: io_addr[1:0], wdata: io_wdata};
      // R11 R12 uart pass-through, reserved read at E9 not strobed
      serial_acc_q <= '{wr_stb: io_wr & hit_ser,
                        rd_stb: io_rd & hit_ser & (io_addr[1:0] != 2'h1),
                        sel: io_addr[1:0], wdata: io_wdata};
      // R11 master reset on write to first serial port
      uart_master_reset_q <= io_wr & hit_ser & (io_addr[1:0] == SER_MASTER_RST);
      // R12 receive holding read clears ready flag
      rx_data_ready_flag_clr_q <= io_rd & hit_ser & (io_addr[1:0] == SER_RX_HOLD);
      // R3 printer write pulse
      printer_strobe_q <= wr_prn;
    end
  end

  // status, waits and read data
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      tick_prev_q       <= 1'b0;
      tick_pending_q    <= 1'b0;
      wait_cnt_q        <= 5'h0;
      disk_sync_wait_q  <= 1'b0;
      io_wait_q         <= 1'b0;
      io_rdata_q        <= IDLE_READ;
      boot_rom_active_q <= 1'b0;
      irq_q             <= 1'b0;
      nmi_q             <= 1'b0;
    end
    else
    begin
      tick_prev_q    <= sy_tick;
      // R10 sticky tick with set priority
      tick_pending_q <= tick_pending_d;
      // R8 stall count
      wait_cnt_q     <= wait_cnt_d;
      // R7 controller sync wait
      disk_sync_wait_q <= disk_sync_wait_d;
      // R8 wait held while counting
      io_wait_q      <= (wait_cnt_d != 5'h0) | disk_sync_wait_d;
      // R2 R4 R12 R14 R16 read data
      io_rdata_q     <= rdata_d;
      // R23 boot rom mapping
      boot_rom_active_q <= boot_active_d;
      irq_q          <= irq_d;
      nmi_q          <= nmi_d;
    end
  end

endmodule : ioc_io_port_control

`default_nettype wire

// >>> sim/ioc_cpu.sv
// Purpose: cpu model for i/o cycles
// Assumes: one-cycle strobes
// Notes:   stalls on io_wait_q
`default_nettype none

module ioc_cpu (
  input  wire logic       mclk,
  input  wire logic       io_wait_q,
  input  wire logic [7:0] io_rdata_q,
  output var  logic [7:0] io_addr,
  output var  logic [7:0] io_wdata,
  output var  logic       io_wr,
  output var  logic       io_rd
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial
  begin
    {io_addr, io_wdata, io_wr, io_rd} = 18'h00000;
  end

  // one cycle; no request while the device stalls us, bounded
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [7:0] q);
    int n;
    n = 0;
    // one edge after the last release
    @(posedge mclk);
    #1;
    while (io_wait_q !== 1'b0 && n < 200)
    begin
      n++;
      @(posedge mclk);
      #1;
    end
    {io_addr, io_wdata, io_wr, io_rd} = {a, v, w, ~w};
    @(posedge mclk);
    #1;
    q = io_rdata_q;
    // release to inverted values, never stale
    {io_addr, io_wdata, io_wr, io_rd} = {~a, ~v, 2'b00};
  endtask : xfer
endmodule : ioc_cpu

`default_nettype wire

// >>> sim/ioc_checker.sv
// Purpose: port latch assertions
// Assumes: one mclk domain
// Notes:   bound below
`default_nettype none

module ioc_checker
  import ioc_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  nrst,
  input wire logic [7:0]            io_addr,
  input wire logic                  io_wr,
  input wire logic                  io_rd,
  input wire logic [7:0]            io_wdata,
  input wire logic [7:0]            io_rdata_q,
  input wire logic                  io_wait_q,
  input wire logic [7:0]            disk_rdata,
  input wire ioc_pkg::ioc_ext_acc_t disk_acc_q,
  input wire logic [7:0]            printer_data_out_q,
  input wire logic                  printer_strobe_q,
  input wire logic                  tape_sound_out_q,
  input wire ioc_pkg::ioc_syscfg_t  system_config_q,
  input wire ioc_pkg::ioc_drive_t   floppy_drive_config_q,
  input wire ioc_pkg::ioc_opctl_t   operation_control_q,
  input wire ioc_pkg::ioc_irqen_t   irq_enable_q,
  input wire logic [1:0]            nmi_enable_q,
  input wire logic                  boot_rom_active_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // group match on addr 7..2
  function automatic logic grp(input logic [7:0] a, input logic [7:0] b);
    return a[7:2] == b[7:2];
  endfunction : grp

  // accepted write to one port group
  sequence s_wr(logic [7:0] p);
    io_wr && grp(io_addr, p);
  endsequence
  // twenty cycles of stall
  sequence s_wait20;
    io_wait_q [*8] ##1 io_wait_q [*8] ##1 io_wait_q [*4];
  endsequence

  a_tape_level: assert property (s_wr(PORT_CFG) |=> tape_sound_out_q == $past(io_wdata[0]))
    else $error("tape level wrong");
  a_printer_byte: assert property (s_wr(PORT_PRINTER) |=> printer_strobe_q && printer_data_out_q == $past(io_wdata))
    else $error("printer byte wrong");
  a_disk_read_route: assert property (io_rd && grp(io_addr, PORT_DISK) |=> disk_acc_q.rd_stb
    && disk_acc_q.sel == $past(io_addr[1:0]) && io_rdata_q == $past(disk_rdata)) else $error("disk read wrong");
  a_drive_latch: assert property (s_wr(PORT_DRIVE) |=> floppy_drive_config_q == ($past(io_wdata) & 8'hF3))
    else $error("drive latch wrong");
  a_drive_stall: assert property (s_wr(PORT_DRIVE) |=> s_wait20)
    else $error("drive stall short");
  a_syscfg_latch: assert property (s_wr(PORT_SYSCFG) |=> system_config_q == ($past(io_wdata[6:0]) & 7'h5E))
    else $error("config latch wrong");
  a_nmi_enables: assert property (s_wr(PORT_NMI) |=> nmi_enable_q == $past(io_wdata[7:6]))
    else $error("nmi enables wrong");
  a_irq_enables: assert property (s_wr(PORT_IRQ) |=> irq_enable_q == ($past(io_wdata) & 8'h7C))
    else $error("irq enables wrong");
  a_opctl_latch: assert property (s_wr(PORT_OPCTL) |=> operation_control_q == $past(io_wdata))
    else $error("operation latch wrong");
  a_boot_mode_zero: assert property (boot_rom_active_q |-> $past(operation_control_q[1:0]) == 2'b00)
    else $error("boot rom outside mode 0");
endmodule : ioc_checker

bind ioc_io_port_control ioc_checker u_ioc_checker (.*);

`default_nettype wire

// >>> sim/tb.sv
// Purpose: directed port latch bench
// Assumes: cpu model stalls itself
// Notes:   pins lag by the sync
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ioc_pkg::*;

  logic         mclk, nrst, io_wr, io_rd, io_wait_q, uart_rst, rx_clr, prn_stb;
  logic         tape_q, snd_q, boot_q, irq_q, nmi_q, req, dreq, motor, tick, ext, txe, rxf, uerr;
  logic [7:0]   io_addr, io_wdata, io_rdata_q, disk_rdata, serial_rdata, printer_data_out_q, d;
  logic [3:0]   printer_stat_pin;
  logic [1:0]   nmi_en;
  ioc_ext_acc_t disk_acc_q, serial_acc_q;
  ioc_syscfg_t  syscfg;
  ioc_drive_t   drv;
  ioc_opctl_t   opctl;
  ioc_irqen_t   irqen;
  int           checks = 0;
  int           miscompares = 0;

  ioc_io_port_control u_ioc_io_port_control (
    .*, .disk_ctrl_request(req), .disk_data_request(dreq), .motor_timeout(motor), .clock_tick(tick),
    .ext_bus_irq(ext), .tx_empty(txe), .rx_full(rxf), .uart_error(uerr), .uart_master_reset_q(uart_rst),
    .rx_data_ready_flag_clr_q(rx_clr), .printer_strobe_q(prn_stb), .tape_sound_out_q(tape_q),
    .sound_data_q(snd_q), .system_config_q(syscfg), .floppy_drive_config_q(drv), .operation_control_q(opctl),
    .irq_enable_q(irqen), .nmi_enable_q(nmi_en), .boot_rom_active_q(boot_q));
  ioc_cpu u_ioc_cpu (.*);

  always #25 mclk = ~mclk;

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_ioc_cpu.xfer(1'b1, a, v, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    u_ioc_cpu.xfer(1'b0, a, 8'h00, d);
  endtask : rd

  // cycles that io_wait_q stays high, bounded
  task automatic stall(output int n);
    n = 0;
    while (io_wait_q === 1'b1 && n < 100)
    begin
      n++;
      cyc(1);
    end
  endtask : stall

  task automatic t_reset_vals;
    chk8(opctl, LATCH_RESET, "opctl");
    chk8(irqen, LATCH_RESET, "irq en");
    chk8(drv, LATCH_RESET, "drive");
    chk8({1'b0, syscfg}, LATCH_RESET, "syscfg");
    chk8({boot_q, tape_q, snd_q, 3'h0, nmi_en}, LATCH_RESET, "misc");
  endtask : t_reset_vals

  task automatic t_latches;
    wr(8'hFF, 8'hFF);
    chk8(8'(tape_q), 8'h01, "tape");
    wr(8'hFC, 8'hFE);
    chk8(8'(tape_q), 8'h00, "tape");
    wr(8'h93, 8'hFF);
    chk8(8'(snd_q), 8'h01, "sound");
    wr(8'hEF, 8'hFF);
    chk8({1'b0, syscfg}, 8'h5E, "syscfg");
    rd(8'hFD);
    chk8(d, 8'h5E, "readback");
    wr(8'h87, 8'hA4);
    chk8(opctl, 8'hA4, "opctl");
    wr(8'h84, 8'h5B);
    chk8(opctl, 8'h5B, "opctl");
  endtask : t_latches

  task automatic t_printer;
    for (int i = 0; i < 2; i++)
    begin
      printer_stat_pin = i ? 4'h6 : 4'h9;
      wr(8'hF9, i ? 8'h3C : 8'hC3);
      chk8(printer_data_out_q, i ? 8'h3C : 8'hC3, "prn data");
      chk8({7'h00, prn_stb}, 8'h01, "prn strobe");
      cyc(6);
      rd(8'hFA);
      chk8(d & 8'hF0, {printer_stat_pin, 4'h0}, "prn status");
    end
  endtask : t_printer

  task automatic t_drive;
    int n;
    wr(8'hF4, 8'hBF);
    chk8(drv, 8'hB3, "drive");
    stall(n);
    chk8(8'(n), 8'h14, "stall");
    wr(8'hF7, 8'h40);
    chk8(drv, 8'h40, "drive");
    stall(n);
    chk8(8'(n), 8'h14, "stall");
    rd(8'hF3);
    cyc(3);
    chk8({7'h00, io_wait_q}, 8'h01, "sync wait");
    dreq = 1'b1;
    stall(n);
    chk8({7'h00, n < 8}, 8'h01, "sync release");
    dreq = 1'b0;
    wr(8'hF4, 8'h00);
    stall(n);
  endtask : t_drive

  task automatic t_disk;
    disk_rdata = 8'h5A;
    rd(8'hF2);
    chk8(d, 8'h5A, "disk rd");
    chk8({4'h0, disk_acc_q[11:8]}, 8'h06, "disk rd stb");
    wr(8'hF1, 8'h77);
    chk8({4'h0, disk_acc_q[11:8]}, 8'h09, "disk wr stb");
    chk8(disk_acc_q.wdata, 8'h77, "disk wdata");
  endtask : t_disk

  task automatic t_serial;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'(8'hE8 + i), 8'(8'h10 + i));
      chk8({serial_acc_q.wr_stb, uart_rst, 4'h0, serial_acc_q.sel}, {1'b1, i == 0, 4'h0, 2'(i)}, "ser wr");
      chk8(serial_acc_q.wdata, 8'(8'h10 + i), "ser wdata");
      serial_rdata = 8'(8'hC0 + i);
      rd(8'(8'hE8 + i));
      chk8(d, i == 1 ? IDLE_READ : serial_rdata, "ser rd");
      chk8({serial_acc_q.rd_stb, rx_clr, 6'h00}, {i != 1, i == 3, 6'h00}, "ser rd stb");
    end
  endtask : t_serial

  task automatic t_nmi;
    wr(8'hE6, 8'hC0);
    chk8({6'h00, nmi_en}, 8'h03, "nmi en");
    wr(8'hE5, 8'h7F);
    chk8({6'h00, nmi_en}, 8'h01, "nmi en");
    req = 1'b1;
    cyc(6);
    rd(8'hE4);
    chk8(d, 8'h60, "nmi status");
    {req, motor} = 2'b01;
    cyc(6);
    rd(8'hE7);
    chk8(d, 8'hA0, "nmi status");
    chk8(8'(nmi_q), 8'h01, "nmi out");
    motor = 1'b0;
  endtask : t_nmi

  task automatic t_irq;
    wr(8'hE1, 8'hFF);
    chk8(irqen, 8'h7C, "irq en");
    {tick, rxf} = 2'b11;
    cyc(6);
    tick = 1'b0;
    cyc(6);
    rd(8'hE0);
    chk8(d, 8'h24, "irq pend");
    chk8(8'(irq_q), 8'h01, "irq out");
    rd(8'hEE);
    {rxf, txe, ext, uerr} = 4'h7;
    cyc(6);
    rd(8'hE2);
    chk8(d, 8'h58, "irq pend");
    wr(8'hE0, 8'h00);
    cyc(2);
    chk8(8'(irq_q), 8'h00, "irq masked");
    {txe, ext, uerr} = 3'h0;
  endtask : t_irq

  task automatic t_boot;
    wr(8'h84, 8'h00);
    wr(8'h9D, 8'h01);
    cyc(1);
    chk8(8'(boot_q), 8'h01, "boot on");
    wr(8'h86, 8'h03);
    cyc(1);
    chk8(8'(boot_q), 8'h00, "boot mode");
    wr(8'h84, 8'h00);
    wr(8'h9C, 8'hFE);
    cyc(1);
    chk8(8'(boot_q), 8'h00, "boot off");
  endtask : t_boot

  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  // watchdog against a hung handshake
  initial
  begin
    repeat (4000) @(posedge mclk);
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end

  initial
  begin
    {mclk, nrst, req, dreq, motor, tick, ext, txe, rxf, uerr} = 10'h000;
    {disk_rdata, serial_rdata, printer_stat_pin} = 20'h00000;
    repeat (2) @(posedge mclk);
    #1;
    nrst = 1'b1;
    cyc(4);
    t_reset_vals();
    t_latches();
    t_printer();
    t_drive();
    t_disk();
    t_serial();
    t_nmi();
    t_irq();
    t_boot();
    // second reset in mid-run
    nrst = 1'b0;
    cyc(1);
    nrst = 1'b1;
    cyc(4);
    t_reset_vals();
    summarize();
  end
endmodule : tb

`default_nettype wire
